// >>> rsp_pkg.sv
/*
 * constants, field layouts and state encodings shared by the serial
 * register port and its alarm register file.
 * assumes: included before any other file of the block.
 */
package rsp_pkg;

  // ************************************************************
  // widths
  // ************************************************************
  localparam int RSP_DATA_W = 8;
  localparam int RSP_ADDR_W = 4;

  // ************************************************************
  // register addresses
  // ************************************************************
  localparam logic [3:0] ADDR_WK_MIN = 4'h8;
  localparam logic [3:0] ADDR_WK_HOUR = 4'h9;
  localparam logic [3:0] ADDR_WK_DAY = 4'hA;
  localparam logic [3:0] ADDR_DY_MIN = 4'hB;
  localparam logic [3:0] ADDR_DY_HOUR = 4'hC;
  localparam logic [3:0] ADDR_STEP = 4'h1;

  // ************************************************************
  // transfer format codes
  // ************************************************************
  localparam logic [3:0] FMT_WR_SINGLE = 4'h8;
  localparam logic [3:0] FMT_WR_BURST = 4'h0;
  localparam logic [3:0] FMT_RD_SINGLE = 4'hC;
  localparam logic [3:0] FMT_RD_BURST = 4'h4;

  // ************************************************************
  // field layouts and reset values
  // ************************************************************
  localparam logic [7:0] MASK_MIN = 8'h7F;
  localparam logic [7:0] MASK_HOUR = 8'h3F;
  localparam logic [7:0] MASK_DAY = 8'h7F;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam int HOUR_PM_BIT = 5;
  localparam logic [2:0] WEEKDAY_MAX = 3'h6;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_STEP = 3'h1;

  // ************************************************************
  // serial engine states
  // ************************************************************
  typedef enum logic [4:0] {
    RSP_IDLE = 5'h01,
    RSP_CMD = 5'h02,
    RSP_WDATA = 5'h04,
    RSP_RDATA = 5'h08,
    RSP_SKIP = 5'h10
  } rsp_state_e;

endpackage

// >>> rsp_reg_if.sv
/*
 * register access path between the serial engine and the alarm
 * register file.
 * assumes: both ends run on mclk.
 */
`timescale 1ns/100ps
`default_nettype none
interface rsp_reg_if;
  import rsp_pkg::*;
  logic wr_en;
  logic [RSP_ADDR_W-1:0] wr_addr;
  logic [RSP_DATA_W-1:0] wr_data;
  logic [RSP_ADDR_W-1:0] rd_addr;
  logic [RSP_DATA_W-1:0] rd_data;

  modport engine (
    output wr_en,
    output wr_addr,
    output wr_data,
    output rd_addr,
    input rd_data
  );

  modport regs (
    input wr_en,
    input wr_addr,
    input wr_data,
    input rd_addr,
    output rd_data
  );
endinterface
`default_nettype wire

// >>> rsp_alarm_regs.sv
/*
 * alarm register file: weekly minute, hour and day mask, daily minute
 * and hour. combinational read, one write per strobe.
 * assumes: wr_en is a one-cycle pulse; weekday and hour mode come from
 * logic on mclk.
 */
`timescale 1ns/100ps
`default_nettype none
module rsp_alarm_regs
  import rsp_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  rsp_reg_if.regs bus,
  input wire logic [RSP_DATA_W-1:0] ext_rdata,
  input wire logic [2:0] weekday_counter_bits,
  input wire logic hour_mode_12,
  output logic weekly_alarm_enable,
  output logic weekly_day_hit,
  output logic [6:0] weekly_alarm_minute,
  output logic [5:0] weekly_alarm_hour,
  output logic [6:0] daily_alarm_minute,
  output logic [5:0] daily_alarm_hour,
  output logic daily_pm_flag,
  output logic daily_hour_tens_bit
);

  // ************************************************************
  // storage
  // ************************************************************
  // alarm values are undefined after power-up; zero is one legal pick
  logic [7:0] wk_min, wk_hour, wk_day, dy_min, dy_hour;
  logic [7:0] next_wk_min, next_wk_hour, next_wk_day;
  logic [7:0] next_dy_min, next_dy_hour;

  always_comb begin
    next_wk_min = wk_min;
    next_wk_hour = wk_hour;
    next_wk_day = wk_day;
    next_dy_min = dy_min;
    next_dy_hour = dy_hour;
    if (bus.wr_en) begin
      unique case (bus.wr_addr)
        ADDR_WK_MIN: next_wk_min = bus.wr_data & MASK_MIN;
        ADDR_WK_HOUR: next_wk_hour = bus.wr_data & MASK_HOUR;
        ADDR_WK_DAY: next_wk_day = bus.wr_data & MASK_DAY;
        ADDR_DY_MIN: next_dy_min = bus.wr_data & MASK_MIN;
        ADDR_DY_HOUR: next_dy_hour = bus.wr_data & MASK_HOUR;
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wk_min <= REG_RESET;
      wk_hour <= REG_RESET;
      wk_day <= REG_RESET;
      dy_min <= REG_RESET;
      dy_hour <= REG_RESET;
    end else begin
      wk_min <= next_wk_min;
      wk_hour <= next_wk_hour;
      wk_day <= next_wk_day;
      dy_min <= next_dy_min;
      dy_hour <= next_dy_hour;
    end
  end

  // ************************************************************
  // read path
  // ************************************************************
  // reserved bits are masked at write, so they read as zero
  always_comb begin
    unique case (bus.rd_addr)
      ADDR_WK_MIN: bus.rd_data = wk_min;
      ADDR_WK_HOUR: bus.rd_data = wk_hour;
      ADDR_WK_DAY: bus.rd_data = wk_day;
      ADDR_DY_MIN: bus.rd_data = dy_min;
      ADDR_DY_HOUR: bus.rd_data = dy_hour;
      default: bus.rd_data = ext_rdata;
    endcase
  end

  // ************************************************************
  // alarm outputs
  // ************************************************************
  logic [6:0] day_sel;
  logic any_day;
  logic next_day_hit;

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_day
      assign day_sel[gi] = wk_day[gi] &&
        (weekday_counter_bits == 3'(gi));
    end
  endgenerate

  assign any_day = |wk_day[6:0];
  assign next_day_hit = |day_sel && weekday_counter_bits <= WEEKDAY_MAX;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      weekly_alarm_enable <= 1'b0;
      weekly_day_hit <= 1'b0;
      weekly_alarm_minute <= '0;
      weekly_alarm_hour <= '0;
      daily_alarm_minute <= '0;
      daily_alarm_hour <= '0;
      daily_pm_flag <= 1'b0;
      daily_hour_tens_bit <= 1'b0;
    end else begin
      // an empty day mask silences the whole weekly set
      weekly_alarm_enable <= any_day;
      weekly_day_hit <= any_day && next_day_hit;
      weekly_alarm_minute <= any_day ? wk_min[6:0] : '0;
      weekly_alarm_hour <= any_day ? wk_hour[5:0] : '0;
      daily_alarm_minute <= dy_min[6:0];
      daily_alarm_hour <= dy_hour[5:0];
      // noon in twelve-hour mode is pm flag plus 12
      daily_pm_flag <= hour_mode_12 && dy_hour[HOUR_PM_BIT];
      daily_hour_tens_bit <= !hour_mode_12 && dy_hour[HOUR_PM_BIT];
    end
  end

endmodule // rsp_alarm_regs
`default_nettype wire

// >>> rsp_serial_port.sv
/*
 * four-wire serial register port: select, serial clock, serial in,
 * serial out. decodes the command byte, runs single and burst reads
 * and writes, and holds the alarm register file.
 * assumes: mclk at 200 MHz, well above the serial clock, so every
 * serial edge is seen after the two-flop synchronisers.
 */
`timescale 1ns/100ps
`default_nettype none

module rsp_serial_port
  import rsp_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic sclk,
  input wire logic si,
  output logic so_out,
  output logic so_oe,
  output logic carry_hold,
  output logic ext_wr,
  output logic [RSP_ADDR_W-1:0] ext_addr,
  output logic [RSP_DATA_W-1:0] ext_wdata,
  input wire logic [RSP_DATA_W-1:0] ext_rdata,
  input wire logic [2:0] weekday_counter_bits,
  input wire logic hour_mode_12,
  output logic weekly_alarm_enable,
  output logic weekly_day_hit,
  output logic [6:0] weekly_alarm_minute,
  output logic [5:0] weekly_alarm_hour,
  output logic [6:0] daily_alarm_minute,
  output logic [5:0] daily_alarm_hour,
  output logic daily_pm_flag,
  output logic daily_hour_tens_bit
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  // the first stage feeds only the second; the third stage is the
  // edge detector's memory
  logic ce_m, ce_s, ce_d;
  logic sclk_m, sclk_s, sclk_d;
  logic si_m, si_s;
  logic next_ce_m, next_ce_s, next_ce_d;
  logic next_sclk_m, next_sclk_s, next_sclk_d;
  logic next_si_m, next_si_s;

  // a bare shift: the pins go straight into the first stage
  always_comb begin
    next_ce_m = ce;
    next_ce_s = ce_m;
    next_ce_d = ce_s;
    next_sclk_m = sclk;
    next_sclk_s = sclk_m;
    next_sclk_d = sclk_s;
    next_si_m = si;
    next_si_s = si_m;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ce_m <= 1'b0;
      ce_s <= 1'b0;
      ce_d <= 1'b0;
      sclk_m <= 1'b0;
      sclk_s <= 1'b0;
      sclk_d <= 1'b0;
      si_m <= 1'b0;
      si_s <= 1'b0;
    end else begin
      ce_m <= next_ce_m;
      ce_s <= next_ce_s;
      ce_d <= next_ce_d;
      sclk_m <= next_sclk_m;
      sclk_s <= next_sclk_s;
      sclk_d <= next_sclk_d;
      si_m <= next_si_m;
      si_s <= next_si_s;
    end
  end

  logic ce_rise;
  logic sclk_rise, sclk_fall;
  assign ce_rise = ce_s && !ce_d;
  assign sclk_rise = sclk_s && !sclk_d;
  assign sclk_fall = !sclk_s && sclk_d;

  // ************************************************************
  // engine state
  // ************************************************************
  rsp_state_e state, next_state;
  logic edge_mode, next_edge_mode;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [7:0] shift_in, next_shift_in;
  logic [7:0] rd_shift, next_rd_shift;
  logic [3:0] addr, next_addr;
  logic [3:0] fmt, next_fmt;
  logic next_so_out, next_so_oe;
  logic wr_en, next_wr_en;
  logic [3:0] wr_addr, next_wr_addr;
  logic [7:0] wr_data, next_wr_data;
  logic next_carry_hold;

  rsp_reg_if regs_bus ();

  // edge_mode 1: sample on rising and drive on falling
  // limitation: each sclk level must last two mclk periods or more, or
  // the synchroniser swallows an edge and the byte slips
  logic sample_edge, drive_edge;
  logic [7:0] byte_in;
  logic [3:0] addr_inc;
  assign sample_edge = edge_mode ? sclk_rise : sclk_fall;
  assign drive_edge = edge_mode ? sclk_fall : sclk_rise;
  assign byte_in = {shift_in[6:0], si_s};
  // four bits wide, so the pointer wraps F to 0 by itself
  assign addr_inc = addr + ADDR_STEP;

  // the byte to preload is read on the sample edge that ends the command byte, before the first drive edge
  always_comb begin
    if (state == RSP_CMD) begin
      regs_bus.rd_addr = byte_in[7:4];
    end else begin
      regs_bus.rd_addr = addr_inc;
    end
  end

  assign regs_bus.wr_en = wr_en;
  assign regs_bus.wr_addr = wr_addr;
  assign regs_bus.wr_data = wr_data;

  // ************************************************************
  // next-state logic
  // ************************************************************
  always_comb begin
    next_state = state;
    next_edge_mode = edge_mode;
    next_bit_cnt = bit_cnt;
    next_shift_in = shift_in;
    next_rd_shift = rd_shift;
    next_addr = addr;
    next_fmt = fmt;
    next_so_out = so_out;
    next_so_oe = so_oe;
    next_wr_en = 1'b0;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_carry_hold = ce_s;
    if (!ce_s) begin
      // any partial byte is simply dropped
      next_state = RSP_IDLE;
      next_bit_cnt = BIT_FIRST;
      next_so_out = 1'b0;
      next_so_oe = 1'b0;
    end else if (ce_rise) begin
      // the sclk level now picks the edge pair for the whole session
      next_state = RSP_CMD;
      next_edge_mode = sclk_s;
      next_bit_cnt = BIT_FIRST;
      next_so_oe = 1'b0;
    end else begin
      if (drive_edge && state == RSP_RDATA) begin
        next_so_out = rd_shift[7];
        next_rd_shift = {rd_shift[6:0], 1'b0};
        next_so_oe = 1'b1;
      end
      // rsp_skip is left out: an unknown format shifts nothing in
      if (sample_edge && (state == RSP_CMD || state == RSP_WDATA ||
          state == RSP_RDATA)) begin
        next_shift_in = byte_in;
        next_bit_cnt = bit_cnt + BIT_STEP;
        if (bit_cnt == BIT_LAST) begin
          unique case (state)
            RSP_CMD: begin
              next_addr = byte_in[7:4];
              next_fmt = byte_in[3:0];
              unique case (byte_in[3:0])
                FMT_WR_SINGLE, FMT_WR_BURST: begin
                  next_state = RSP_WDATA;
                end
                FMT_RD_SINGLE, FMT_RD_BURST: begin
                  next_state = RSP_RDATA;
                  next_rd_shift = regs_bus.rd_data;
                end
                // unknown formats are ignored until select falls
                default: next_state = RSP_SKIP;
              endcase
            end
            RSP_WDATA: begin
              // strobe for every address; the alarm file keeps its own
              next_wr_en = 1'b1;
              next_wr_addr = addr;
              next_wr_data = byte_in;
              if (fmt == FMT_WR_SINGLE) begin
                next_state = RSP_CMD;
              end else begin
                next_addr = addr_inc;
              end
            end
            RSP_RDATA: begin
              if (fmt == FMT_RD_SINGLE) begin
                next_state = RSP_CMD;
                next_so_out = 1'b0;
                next_so_oe = 1'b0;
              end else begin
                next_addr = addr_inc;
                next_rd_shift = regs_bus.rd_data;
              end
            end
            default: ;
          endcase
        end
      end
    end
  end

  // ************************************************************
  // state registers
  // ************************************************************
  // so_out, so_oe and carry_hold leave the block straight from here
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= RSP_IDLE;
      edge_mode <= 1'b0;
      bit_cnt <= BIT_FIRST;
      shift_in <= BYTE_ZERO;
      rd_shift <= BYTE_ZERO;
      addr <= '0;
      fmt <= '0;
      so_out <= 1'b0;
      so_oe <= 1'b0;
      wr_en <= 1'b0;
      wr_addr <= '0;
      wr_data <= BYTE_ZERO;
      carry_hold <= 1'b0;
    end else begin
      state <= next_state;
      edge_mode <= next_edge_mode;
      bit_cnt <= next_bit_cnt;
      shift_in <= next_shift_in;
      rd_shift <= next_rd_shift;
      addr <= next_addr;
      fmt <= next_fmt;
      so_out <= next_so_out;
      so_oe <= next_so_oe;
      wr_en <= next_wr_en;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      carry_hold <= next_carry_hold;
    end
  end

  // every write is shown outside too; the time counters pick their own
  assign ext_wr = wr_en;
  assign ext_addr = wr_addr;
  assign ext_wdata = wr_data;

  // ************************************************************
  // alarm register file
  // ************************************************************
  rsp_alarm_regs u_alarm_regs (
    .mclk(mclk),
    .resetn(resetn),
    .bus(regs_bus.regs),
    .ext_rdata(ext_rdata),
    .weekday_counter_bits(weekday_counter_bits),
    .hour_mode_12(hour_mode_12),
    .weekly_alarm_enable(weekly_alarm_enable),
    .weekly_day_hit(weekly_day_hit),
    .weekly_alarm_minute(weekly_alarm_minute),
    .weekly_alarm_hour(weekly_alarm_hour),
    .daily_alarm_minute(daily_alarm_minute),
    .daily_alarm_hour(daily_alarm_hour),
    .daily_pm_flag(daily_pm_flag),
    .daily_hour_tens_bit(daily_hour_tens_bit)
  );

endmodule // rsp_serial_port
`default_nettype wire

// >>> rsp_serial_port_asserts.sv
/*
 * concurrent checks on the serial register port, bound to its top.
 * assumes: one clock domain, mclk, with resetn as its async reset.
 */
`timescale 1ns/100ps
`default_nettype none
module rsp_serial_port_asserts (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic so_oe,
  input wire logic carry_hold,
  input wire logic ext_wr,
  input wire logic [2:0] weekday_counter_bits,
  input wire logic weekly_alarm_enable,
  input wire logic weekly_day_hit,
  input wire logic [6:0] weekly_alarm_minute,
  input wire logic [5:0] weekly_alarm_hour,
  input wire logic [5:0] daily_alarm_hour,
  input wire logic daily_pm_flag,
  input wire logic daily_hour_tens_bit
);
  // ************************************************************
  // properties
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence ce_up; $rose(ce); endsequence
  sequence ce_down; $fell(ce); endsequence
  // long enough for the synchroniser to flush
  sequence ce_quiet; !ce [*6]; endsequence

  hold_set_a: assert property (ce_up |-> ##[1:5] carry_hold)
    else $error("carry hold late after select rise");
  hold_free_a: assert property (ce_down |-> ##[1:5] !carry_hold)
    else $error("carry hold late after select fall");
  oe_idle_a: assert property (ce_quiet |-> !so_oe)
    else $error("serial output driven outside a session");
  oe_session_a: assert property ($rose(so_oe) |-> carry_hold)
    else $error("serial output enabled without a session");
  wr_pulse_a: assert property (ext_wr |=> !ext_wr)
    else $error("write strobe longer than one cycle");
  wr_session_a: assert property (ext_wr |-> carry_hold)
    else $error("write strobe outside a session");
  empty_mask_a: assert property (!weekly_alarm_enable |->
    weekly_alarm_minute == 7'h00 && weekly_alarm_hour == 6'h00
    && !weekly_day_hit) else $error("weekly outputs with empty mask");
  no_day7_a: assert property (weekday_counter_bits == 3'h7 [*2]
    |-> !weekly_day_hit) else $error("weekday code 7 hit");
  flag_excl_a: assert property (
    !(daily_pm_flag && daily_hour_tens_bit))
    else $error("pm flag and tens bit both set");
  flag_cause_a: assert property (!daily_alarm_hour[5] [*2] |->
    !daily_pm_flag && !daily_hour_tens_bit)
    else $error("hour flag without hour bit 5");
endmodule // rsp_serial_port_asserts

bind rsp_serial_port rsp_serial_port_asserts i_rsp_serial_port_asserts (
  .mclk(mclk), .resetn(resetn), .ce(ce), .so_oe(so_oe),
  .carry_hold(carry_hold), .ext_wr(ext_wr),
  .weekday_counter_bits(weekday_counter_bits),
  .weekly_alarm_enable(weekly_alarm_enable),
  .weekly_day_hit(weekly_day_hit),
  .weekly_alarm_minute(weekly_alarm_minute),
  .weekly_alarm_hour(weekly_alarm_hour),
  .daily_alarm_hour(daily_alarm_hour), .daily_pm_flag(daily_pm_flag),
  .daily_hour_tens_bit(daily_hour_tens_bit));
`default_nettype wire

// >>> rsp_host.sv
/*
 * host model: drives select, serial clock and serial input, samples
 * serial output. 48 ns serial clock, still between sessions.
 * assumes: tasks called in sequence by the bench.
 */
`timescale 1ns/100ps
`default_nettype none
module rsp_host (
  output logic ce,
  output logic sclk,
  output logic si,
  input wire logic so
);
  // ************************************************************
  // session and bit tasks
  // ************************************************************
  logic idle;
  initial begin
    ce = 1'b0;
    sclk = 1'b0;
    si = 1'b0;
    idle = 1'b0;
  end
  // sclk level at select rise picks the edge pair
  task automatic open(input logic m);
    idle = m;
    sclk = m;
    #30 ce = 1'b1;
    #30;
  endtask
  task automatic close();
    #30 ce = 1'b0;
    #60;
  endtask
  // n bits of d, msb first; so is taken just before each sample edge
  task automatic xfer(input logic [7:0] d, input int n,
                      output logic [7:0] q);
    q = 8'h00;
    for (int i = 7; i >= 8 - n; i--) begin
      si = d[i];
      sclk = ~idle;
      #24 q[i] = so;
      sclk = idle;
      // data moves away once the sample edge has passed
      #12 si = ~si;
      #12;
    end
  endtask
endmodule // rsp_host
`default_nettype wire

// >>> rsp_serial_port_tb.sv
/*
 * self-checking bench for the serial register port.
 * assumes: rsp_host drives the serial pins; mclk 200 MHz.
 */
`timescale 1ns/100ps
`default_nettype none
module rsp_serial_port_tb;
  import rsp_pkg::*;
  // ************************************************************
  // harness
  // ************************************************************
  logic mclk, resetn, ce, sclk, si, so_out, so_oe, carry_hold, ext_wr;
  logic so_pin;
  logic [3:0] ext_addr;
  logic [7:0] ext_wdata, ext_rdata;
  logic [2:0] wd;
  logic h12, wen, hit, pm, tens;
  logic [6:0] wmin, dmin;
  logic [5:0] whr, dhr;
  logic [31:0] seed = 32'hF0B6;
  logic [7:0] exp_reg [16];
  int fails = 0;
  int n_compared = 0;

  rsp_serial_port i_rsp_serial_port (.mclk(mclk), .resetn(resetn),
    .ce(ce), .sclk(sclk), .si(si), .so_out(so_out), .so_oe(so_oe),
    .carry_hold(carry_hold), .ext_wr(ext_wr), .ext_addr(ext_addr),
    .ext_wdata(ext_wdata), .ext_rdata(ext_rdata),
    .weekday_counter_bits(wd), .hour_mode_12(h12),
    .weekly_alarm_enable(wen), .weekly_day_hit(hit),
    .weekly_alarm_minute(wmin), .weekly_alarm_hour(whr),
    .daily_alarm_minute(dmin), .daily_alarm_hour(dhr),
    .daily_pm_flag(pm), .daily_hour_tens_bit(tens));
  // a released output shows the inverse, so a lost enable breaks the read
  assign so_pin = so_oe ? so_out : ~so_out;
  rsp_host i_rsp_host (.ce(ce), .sclk(sclk), .si(si), .so(so_pin));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  function automatic logic [7:0] rmask(input logic [3:0] a);
    return (a == ADDR_DY_HOUR || a == ADDR_WK_HOUR) ? MASK_HOUR : MASK_MIN;
  endfunction
  // only times that can occur, in bcd; the day mask is random
  function automatic logic [7:0] legal(input logic [3:0] a);
    int n;
    n = rnd() % ((rmask(a) == MASK_HOUR) ? 24 : 60);
    if (a == ADDR_WK_DAY) return rnd() & MASK_DAY;
    return 8'((n / 10) * 16 + n % 10);
  endfunction
  function automatic logic [7:0] expv(input logic [3:0] a);
    return (a >= ADDR_WK_MIN && a <= ADDR_DY_HOUR) ? exp_reg[a] : ext_rdata;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    n_compared++;
    if (got !== want) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic put(input logic [7:0] d, input int n = 8);
    logic [7:0] q;
    i_rsp_host.xfer(d, n, q);
  endtask
  task automatic wr1(input logic [3:0] a, input logic [7:0] d);
    i_rsp_host.open(rnd() > 8'h7F);
    put({a, FMT_WR_SINGLE});
    put(d);
    i_rsp_host.close();
    if (a >= ADDR_WK_MIN && a <= ADDR_DY_HOUR) exp_reg[a] = d & rmask(a);
  endtask
  task automatic rd1(input logic [3:0] a);
    logic [7:0] q;
    i_rsp_host.open(rnd() > 8'h7F);
    put({a, FMT_RD_SINGLE});
    i_rsp_host.xfer(rnd(), 8, q);
    i_rsp_host.close();
    chk(q, expv(a));
  endtask

  initial begin
    #300000;
    fails++;
    $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    end_of_test();
  end

  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    logic [7:0] d, q;
    logic [3:0] a4;
    resetn = 1'b0;
    wd = 3'h0;
    h12 = 1'b0;
    ext_rdata = 8'h00;
    for (int i = 0; i < 16; i++) exp_reg[i] = REG_RESET;
    repeat (4) @(posedge mclk);
    @(negedge mclk) resetn <= 1'b1;
    // keeps every host edge away from mclk rising edges
    #20.3;
    @(negedge mclk) ext_rdata = rnd();
    for (int m = 0; m < 2; m++) begin
      for (int a = 8; a <= 12; a++) begin
        a4 = 4'(a);
        d = legal(a4) | (rnd() & ~rmask(a4));
        i_rsp_host.open(m[0]);
        chk({7'h0, carry_hold}, 8'h01);
        put({a4, FMT_WR_SINGLE});
        put(d);
        chk({4'h0, ext_addr}, {4'h0, a4});
        chk(ext_wdata, d);
        put({a4, FMT_RD_SINGLE});
        i_rsp_host.xfer(rnd(), 8, q);
        chk({7'h0, so_oe}, 8'h00);
        i_rsp_host.close();
        chk({7'h0, carry_hold}, 8'h00);
        exp_reg[a4] = d & rmask(a4);
        chk(q, exp_reg[a4]);
      end
    end
    $display("test single done");
    i_rsp_host.open(1'b1);
    put({4'hF, FMT_WR_BURST});
    for (int k = 0; k < 14; k++) begin
      a4 = 4'hF + 4'(k);
      d = legal(a4);
      put(d);
      if (a4 >= ADDR_WK_MIN && a4 <= ADDR_DY_HOUR) exp_reg[a4] = d & rmask(a4);
    end
    i_rsp_host.close();
    @(negedge mclk) ext_rdata = rnd();
    i_rsp_host.open(1'b0);
    put({4'hF, FMT_RD_BURST});
    for (int k = 0; k < 14; k++) begin
      i_rsp_host.xfer(rnd(), 8, q);
      chk(q, expv(4'hF + 4'(k)));
      chk({7'h0, so_oe}, 8'h01);
    end
    i_rsp_host.close();
    $display("test burst done");
    i_rsp_host.open(1'b0);
    put({ADDR_DY_MIN, FMT_WR_SINGLE});
    put(8'h59, 5);
    i_rsp_host.close();
    i_rsp_host.open(1'b1);
    put({ADDR_DY_MIN, FMT_WR_BURST}, 3);
    i_rsp_host.close();
    // unknown format: the rest of the session must be ignored
    i_rsp_host.open(1'b0);
    put({ADDR_DY_MIN, 4'h3});
    put(8'h01);
    i_rsp_host.close();
    rd1(ADDR_DY_MIN);
    chk({1'b0, dmin}, exp_reg[ADDR_DY_MIN]);
    $display("test abort done");
    wr1(ADDR_WK_DAY, 8'h00);
    #30;
    chk({7'h0, wen}, 8'h00);
    chk({1'b0, wmin}, 8'h00);
    chk({2'h0, whr}, 8'h00);
    d = legal(ADDR_WK_DAY) | 8'h01;
    wr1(ADDR_WK_DAY, d);
    for (int w = 0; w < 8; w++) begin
      @(negedge mclk) wd = 3'(w);
      #30;
      chk({7'h0, hit}, {7'h0, w < 7 && d[w]});
    end
    chk({7'h0, wen}, 8'h01);
    chk({1'b0, wmin}, exp_reg[ADDR_WK_MIN]);
    chk({2'h0, whr}, exp_reg[ADDR_WK_HOUR]);
    rd1(ADDR_WK_DAY);
    $display("test weekly done");
    @(negedge mclk) h12 = 1'b1;
    wr1(ADDR_DY_HOUR, 8'h12);
    #30;
    chk({pm, tens, dhr}, 8'h12);
    wr1(ADDR_DY_HOUR, 8'h32);
    #30;
    chk({pm, tens, dhr}, 8'hB2);
    @(negedge mclk) h12 = 1'b0;
    wr1(ADDR_DY_HOUR, 8'h21);
    #30;
    chk({pm, tens, dhr}, 8'h61);
    rd1(ADDR_DY_HOUR);
    $display("test hour done");
    end_of_test();
  end
endmodule // rsp_serial_port_tb
`default_nettype wire
